// *** hdl/epi_pcgrp.v ***
// Change detector for one pin-change group
`timescale 1ns/10ps
module epi_pcgrp
(
  cur,
  prev,
  pin_mask,
  grp_en,
  hit
);
  input  wire [7:0] cur;
  input  wire [7:0] prev;
  input  wire [7:0] pin_mask;
  input  wire       grp_en;
  output wire       hit;

  // Any unmasked pin whose sample differs from the last one
  assign hit = grp_en & (|((cur ^ prev) & pin_mask));
endmodule

// *** hdl/epi_sync.v ***
// Two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
module epi_sync
#(
  parameter W = 32
)
(
  clk,
  nrst,
  din,
  dout
);
  input  wire         clk;
  input  wire         nrst;
  input  wire [W-1:0] din;
  output reg  [W-1:0] dout;

  reg [W-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// *** hdl/epi_top.v ***
// External interrupt pin and pin-change interrupt unit with Avalon-MM register port
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`include "epi_regs.vh"
module epi_top
#(
  parameter HAS_GRP23 = 1,
  parameter NPINS     = 31
)
(
  clk,
  nrst,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  dedicated_irq_pin,
  pc_pins,
  vector_taken,
  vector_id,
  vector_req,
  irq,
  wake
);
  input  wire             clk;
  input  wire             nrst;
  input  wire [7:0]       avs_address;
  input  wire             avs_read;
  input  wire             avs_write;
  input  wire [31:0]      avs_writedata;
  input  wire [3:0]       avs_byteenable;
  output reg  [31:0]      avs_readdata;
  output reg              avs_waitrequest;
  input  wire             dedicated_irq_pin;
  input  wire [NPINS-1:0] pc_pins;
  input  wire             vector_taken;
  input  wire [2:0]       vector_id;
  output reg  [4:0]       vector_req;
  output reg              irq;
  output reg              wake;

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0]  enable_mask_r;
  reg  [7:0]  flags_r;
  reg  [7:0]  flags_nxt;
  reg  [7:0]  sense_r;
  reg  [7:0]  global_r;
  reg  [31:0] pcmask_r;
  reg  [31:0] pin_prev_r;
  reg         ded_prev_r;
  reg  [2:0]  prime_r;
  reg  [7:0]  rd_mux;
  reg  [4:0]  req_nxt;

  wire [31:0] pin_cur;
  wire        ded_cur;
  wire [3:0]  grp_hit;
  wire [7:0]  wdata;
  wire        wr_go;
  wire        wr_lane;
  wire        gie;
  wire [1:0]  sense;
  wire        level_mode;
  wire        ded_edge;
  wire        ded_level;
  wire [3:0]  grp_en;
  wire [7:0]  flag_rd;
  wire [31:0] pins_padded;
  wire        hist_ok;

  assign wdata   = avs_writedata[7:0];
  assign wr_lane = avs_byteenable[0];
  assign wr_go   = avs_write & ~avs_waitrequest & wr_lane;
  assign gie     = global_r[`EPI_BIT_GLOBAL_EN];
  assign sense   = {sense_r[`EPI_BIT_SENSE_HI], sense_r[`EPI_BIT_SENSE_LO]};

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  // Unused upper pin positions read as steady zero
  assign pins_padded = {{(32-NPINS){1'b0}}, pc_pins};

  // Pin-change pins and the dedicated pin pass two flip-flops
  epi_sync #(.W(32)) u_pc_sync
  (
    .clk  (clk),
    .nrst (nrst),
    .din  (pins_padded),
    .dout (pin_cur)
  );

  epi_sync #(.W(1)) u_ded_sync
  (
    .clk  (clk),
    .nrst (nrst),
    .din  (dedicated_irq_pin),
    .dout (ded_cur)
  );

  // Previous samples for change and edge comparison
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_prev_r <= 32'h00000000;
      ded_prev_r <= 1'b0;
    end
    else
    begin
      pin_prev_r <= pin_cur;
      ded_prev_r <= ded_cur;
    end
  end

  // Comparisons count only once both pipelines hold real pin levels, never reset zeros
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prime_r <= 3'h0;
    end
    else
    begin
      prime_r <= {prime_r[1:0], 1'b1};
    end
  end

  assign hist_ok = prime_r[2];

  //////////////////////////////////////////////////////////////////////////////
  // Pin-change groups

  // Group enables; absent groups stay disabled
  assign grp_en[0] = enable_mask_r[`EPI_BIT_GRP0];
  assign grp_en[1] = enable_mask_r[`EPI_BIT_GRP0 + 1];
  assign grp_en[2] = enable_mask_r[`EPI_BIT_GRP0 + 2];
  assign grp_en[3] = enable_mask_r[`EPI_BIT_GRP0 + 3];

  // One change detector per group of eight pins
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : grp
      epi_pcgrp u_grp
      (
        .cur      (pin_cur[8*g+7:8*g]),
        .prev     (pin_prev_r[8*g+7:8*g]),
        .pin_mask (pcmask_r[8*g+7:8*g]),
        .grp_en   (grp_en[g] & hist_ok),
        .hit      (grp_hit[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Dedicated pin sense

  // Edge or change on the sampled pin per sense code
  assign level_mode = (sense == `EPI_SENSE_LOW);
  assign ded_edge   = hist_ok &
                      (((sense == `EPI_SENSE_ANY)  & (ded_cur ^ ded_prev_r)) |
                       ((sense == `EPI_SENSE_FALL) & ~ded_cur & ded_prev_r) |
                       ((sense == `EPI_SENSE_RISE) & ded_cur & ~ded_prev_r));

  // Low level needs no history, so it holds while the pin is low
  assign ded_level  = level_mode & ~ded_cur;

  //////////////////////////////////////////////////////////////////////////////
  // Flags

  // Set wins over vector entry and write-one clear
  always @*
  begin
    flags_nxt = flags_r;
    if (wr_go && (avs_address == `EPI_IDX_FLAGS))
    begin
      flags_nxt = flags_nxt & ~wdata;
    end
    if (vector_taken)
    begin
      if (vector_id == 3'h0)
      begin
        flags_nxt[`EPI_BIT_DEDICATED] = 1'b0;
      end
      else if (vector_id <= 3'h4)
      begin
        flags_nxt[`EPI_BIT_GRP0 + vector_id - 3'h1] = 1'b0;
      end
    end
    if (ded_edge && !level_mode)
    begin
      flags_nxt[`EPI_BIT_DEDICATED] = 1'b1;
    end
    if (level_mode)
    begin
      flags_nxt[`EPI_BIT_DEDICATED] = 1'b0;
    end
    if (grp_hit[0])
    begin
      flags_nxt[`EPI_BIT_GRP0] = 1'b1;
    end
    if (grp_hit[1])
    begin
      flags_nxt[`EPI_BIT_GRP0 + 1] = 1'b1;
    end
    if (grp_hit[2] && (HAS_GRP23 != 0))
    begin
      flags_nxt[`EPI_BIT_GRP0 + 2] = 1'b1;
    end
    if (grp_hit[3] && (HAS_GRP23 != 0))
    begin
      flags_nxt[`EPI_BIT_GRP0 + 3] = 1'b1;
    end
    flags_nxt[3:1] = 3'h0;
    if (HAS_GRP23 == 0)
    begin
      flags_nxt[7:6] = 2'h0;
    end
  end

  assign flag_rd = flags_r;

  //////////////////////////////////////////////////////////////////////////////
  // Vector requests

  // Each vector needs its flag (or low level), its enable and the global enable
  always @*
  begin
    req_nxt[0] = gie & enable_mask_r[`EPI_BIT_DEDICATED] &
                 (level_mode ? ded_level : flags_r[`EPI_BIT_DEDICATED]);
    req_nxt[1] = gie & grp_en[0] & flags_r[`EPI_BIT_GRP0];
    req_nxt[2] = gie & grp_en[1] & flags_r[`EPI_BIT_GRP0 + 1];
    req_nxt[3] = gie & grp_en[2] & flags_r[`EPI_BIT_GRP0 + 2];
    req_nxt[4] = gie & grp_en[3] & flags_r[`EPI_BIT_GRP0 + 3];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes and state update

  // Software-writable registers, flags and request outputs
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable_mask_r <= `EPI_RST_ENABLE_MASK;
      flags_r       <= `EPI_RST_FLAGS;
      sense_r       <= `EPI_RST_SENSE;
      global_r      <= `EPI_RST_GLOBAL;
      pcmask_r      <= {4{`EPI_RST_PCMASK}};
      vector_req    <= 5'h00;
      irq           <= 1'b0;
      wake          <= 1'b0;
    end
    else
    begin
      flags_r    <= flags_nxt;
      vector_req <= req_nxt;
      irq        <= |req_nxt;
      wake       <= ded_level & enable_mask_r[`EPI_BIT_DEDICATED] | (|grp_hit);
      if (wr_go)
      begin
        case (avs_address)
          `EPI_IDX_ENABLE_MASK:
          begin
            enable_mask_r <= wdata & `EPI_ENABLE_WMASK &
                             ((HAS_GRP23 != 0) ? 8'hff : 8'h3f);
          end
          `EPI_IDX_SENSE:
          begin
            sense_r <= wdata & `EPI_SENSE_WMASK;
          end
          `EPI_IDX_GLOBAL:
          begin
            global_r <= wdata & 8'h01;
          end
          `EPI_IDX_PCMASK0:
          begin
            pcmask_r[7:0] <= wdata;
          end
          `EPI_IDX_PCMASK1:
          begin
            pcmask_r[15:8] <= wdata;
          end
          `EPI_IDX_PCMASK2:
          begin
            pcmask_r[23:16] <= (HAS_GRP23 != 0) ? wdata : 8'h00;
          end
          `EPI_IDX_PCMASK3:
          begin
            pcmask_r[31:24] <= (HAS_GRP23 != 0) ? (wdata & `EPI_PCMASK3_WMASK) : 8'h00;
          end
          default:
          begin
            global_r <= global_r;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave

  // Read multiplexer; unmapped addresses read zero
  always @*
  begin
    case (avs_address)
      `EPI_IDX_ENABLE_MASK: rd_mux = enable_mask_r;
      `EPI_IDX_FLAGS:       rd_mux = flag_rd;
      `EPI_IDX_GLOBAL:      rd_mux = global_r;
      `EPI_IDX_SENSE:       rd_mux = sense_r;
      `EPI_IDX_PCMASK0:     rd_mux = pcmask_r[7:0];
      `EPI_IDX_PCMASK1:     rd_mux = pcmask_r[15:8];
      `EPI_IDX_PCMASK2:     rd_mux = pcmask_r[23:16];
      `EPI_IDX_PCMASK3:     rd_mux = pcmask_r[31:24];
      default:              rd_mux = 8'h00;
    endcase
  end

  // Waitrequest idles high and drops for one cycle, one cycle after a request
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else
    begin
      if ((avs_read || avs_write) && avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h000000, rd_mux};
      end
      else
      begin
        avs_waitrequest <= 1'b1;
      end
    end
  end
endmodule

// *** include/epi_regs.vh ***
// Register map, field positions and reset values of the external/pin-change interrupt unit
`ifndef EPI_REGS_VH
`define EPI_REGS_VH

// Register indices; byte address is four times the index
`define EPI_IDX_ENABLE_MASK 8'h1d
`define EPI_IDX_FLAGS       8'h1c
`define EPI_IDX_GLOBAL      8'h1e
`define EPI_IDX_SENSE       8'h69
`define EPI_IDX_PCMASK0     8'h6b
`define EPI_IDX_PCMASK1     8'h6c
`define EPI_IDX_PCMASK2     8'h6d
`define EPI_IDX_PCMASK3     8'h73

// Field positions
`define EPI_BIT_DEDICATED   0
`define EPI_BIT_GRP0        4
`define EPI_BIT_GLOBAL_EN   0
`define EPI_BIT_SENSE_HI    1
`define EPI_BIT_SENSE_LO    0

// Writable bits of each register
`define EPI_ENABLE_WMASK    8'hf1
`define EPI_SENSE_WMASK     8'h03
`define EPI_PCMASK3_WMASK   8'h7f

// Reset values
`define EPI_RST_ENABLE_MASK 8'h00
`define EPI_RST_FLAGS       8'h00
`define EPI_RST_SENSE       8'h00
`define EPI_RST_PCMASK      8'h00
`define EPI_RST_GLOBAL      8'h00

// Sense codes
`define EPI_SENSE_LOW       2'h0
`define EPI_SENSE_ANY       2'h1
`define EPI_SENSE_FALL      2'h2
`define EPI_SENSE_RISE      2'h3

`endif

// *** verif/epi_pin_model.sv ***
// Outside circuits driving the dedicated pin and the pin-change pins
`timescale 1ns/10ps
module epi_pin_model
(
  input  wire logic        clk,
  input  wire logic        ded_req,
  input  wire logic [30:0] pc_req,
  output logic             dedicated_irq_pin = 1'b1,
  output logic [30:0]      pc_pins = 31'h0
);
  // Levels move just after an edge and stand for whole clock periods
  always @(posedge clk)
  begin
    dedicated_irq_pin <= ded_req;
    pc_pins           <= pc_req;
  end
endmodule

// *** verif/epi_top_asserts.sv ***
// Concurrent checks on the ports of the interrupt unit
`timescale 1ns/10ps
module epi_top_asserts
#(
  parameter HAS_GRP23 = 1,
  parameter NPINS     = 31
)
(
  input wire             clk,
  input wire             nrst,
  input wire [7:0]       avs_address,
  input wire             avs_read,
  input wire             avs_write,
  input wire [31:0]      avs_writedata,
  input wire [3:0]       avs_byteenable,
  input wire [31:0]      avs_readdata,
  input wire             avs_waitrequest,
  input wire             dedicated_irq_pin,
  input wire [NPINS-1:0] pc_pins,
  input wire             vector_taken,
  input wire [2:0]       vector_id,
  input wire [4:0]       vector_req,
  input wire             irq,
  input wire             wake
);
  logic [7:0] prev_r;
  logic [2:0] quiet_r;
  // Cycles since group-0 pins last moved, saturating
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_r  <= 8'h00;
      quiet_r <= 3'h0;
    end
    else
    begin
      prev_r  <= pc_pins[7:0];
      quiet_r <= (pc_pins[7:0] != prev_r) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_take_grp0;
    vector_taken && vector_id == 3'h1 && quiet_r >= 3'h3;
  endsequence
  a_wait_answer: assert property (s_bus_req |=> !avs_waitrequest)
    else $error("waitrequest did not drop after a request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_irq_or_req: assert property (irq == (|vector_req))
    else $error("irq differs from the request vector");
  a_read_upper: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_rdata_hold: assert property (!(avs_read || avs_write) |=> $stable(avs_readdata))
    else $error("read data moved without a request");
  a_reset_quiet: assert property (!$past(nrst) |-> avs_waitrequest && vector_req == 5'h00)
    else $error("outputs not idle after reset");
  a_grp0_cause: assert property ($rose(vector_req[1]) && !$past(avs_write) &&
    !$past(avs_write, 2) |-> $past(pc_pins[7:0], 4) != $past(pc_pins[7:0], 5))
    else $error("group-0 request without a pin change");
  a_take_clears: assert property (s_take_grp0 |=> ##1 !vector_req[1])
    else $error("group-0 request stayed after vector entry");
endmodule
bind epi_top epi_top_asserts #(.HAS_GRP23(HAS_GRP23), .NPINS(NPINS)) u_chk
(
  .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .dedicated_irq_pin(dedicated_irq_pin), .pc_pins(pc_pins), .vector_taken(vector_taken),
  .vector_id(vector_id), .vector_req(vector_req), .irq(irq), .wake(wake)
);

// *** verif/tb_ext_and_pin_change_irq.sv ***
// Self-checking bench of the external and pin-change interrupt unit
`timescale 1ns/10ps
`include "epi_regs.vh"
module tb_ext_and_pin_change_irq;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  logic        ded_req = 1'b1;
  logic [30:0] pc_req = 31'h0;
  wire         ded_pin;
  wire  [30:0] pc_pins;
  logic        vector_taken = 1'b0;
  logic [2:0]  vector_id = 3'h0;
  wire  [4:0]  vector_req;
  wire         irq;
  wire         wake;
  logic [7:0]  q;
  logic [7:0]  pm [4] = '{`EPI_IDX_PCMASK0, `EPI_IDX_PCMASK1, `EPI_IDX_PCMASK2, `EPI_IDX_PCMASK3};
  int          error_cnt = 0;
  int          cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  epi_pin_model u_pins
  (
    .clk(clk), .ded_req(ded_req), .pc_req(pc_req), .dedicated_irq_pin(ded_pin), .pc_pins(pc_pins)
  );
  epi_top #(.HAS_GRP23(1), .NPINS(31)) dut
  (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dedicated_irq_pin(ded_pin), .pc_pins(pc_pins), .vector_taken(vector_taken),
    .vector_id(vector_id), .vector_req(vector_req), .irq(irq), .wake(wake)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus access, held until waitrequest is sampled low; read data lands in q
  task bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= we;
    avs_read      <= !we;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wt;
    repeat (8) @(posedge clk);
  endtask
  // Vector entry pulse
  task take(input logic [2:0] id);
    @(posedge clk);
    vector_taken <= 1'b1;
    vector_id    <= id;
    @(posedge clk);
    vector_taken <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    bus(1'b1, `EPI_IDX_ENABLE_MASK, 8'hff);
    bus(1'b0, `EPI_IDX_ENABLE_MASK, 8'h00);
    chk("mask_bits", 8'hf1, q);
    bus(1'b1, `EPI_IDX_ENABLE_MASK, 8'h00);
    avs_byteenable <= 4'he;
    bus(1'b1, `EPI_IDX_ENABLE_MASK, 8'hff);
    avs_byteenable <= 4'hf;
    bus(1'b0, `EPI_IDX_ENABLE_MASK, 8'h00);
    chk("lane_off", 8'h00, q);
    bus(1'b1, `EPI_IDX_PCMASK3, 8'hff);
    bus(1'b0, `EPI_IDX_PCMASK3, 8'h00);
    chk("pcmask3_bits", 8'h7f, q);
    bus(1'b1, `EPI_IDX_PCMASK3, 8'h00);
    bus(1'b0, 8'h00, 8'h00);
    chk("unmapped", 0, q);
    $display("test regs done");
  endtask
  task t_groups;
    bus(1'b1, `EPI_IDX_GLOBAL, 8'h01);
    for (int g = 0; g < 4; g++)
    begin
      bus(1'b1, pm[g], 8'h01);
      bus(1'b1, `EPI_IDX_ENABLE_MASK, 8'h10 << g);
      pc_req[8 * g + 1] <= ~pc_req[8 * g + 1];
      wt;
      chk("masked_pin", 0, irq);
      pc_req[8 * g] <= ~pc_req[8 * g];
      wt;
      chk("grp_req", 5'h02 << g, vector_req);
      bus(1'b0, `EPI_IDX_FLAGS, 8'h00);
      chk("grp_flag", 8'h10 << g, q);
      take(g[2:0] + 3'h1);
      chk("grp_clear", 0, irq);
      bus(1'b1, pm[g], 8'h00);
    end
    $display("test groups done");
  endtask
  task t_ded;
    bus(1'b1, `EPI_IDX_ENABLE_MASK, 8'h01);
    for (int m = 1; m < 4; m++)
    begin
      bus(1'b1, `EPI_IDX_SENSE, m[7:0]);
      ded_req <= (m != 3);
      wt;
      bus(1'b1, `EPI_IDX_FLAGS, 8'h01);
      ded_req <= (m == 3);
      wt;
      chk("edge_irq", 1, irq);
      bus(1'b1, `EPI_IDX_FLAGS, 8'h00);
      bus(1'b0, `EPI_IDX_FLAGS, 8'h00);
      chk("flag_kept", 8'h01, q);
      bus(1'b1, `EPI_IDX_FLAGS, 8'h01);
      ded_req <= (m != 3);
      wt;
      chk("back_edge", (m == 1), irq);
      if (m == 1)
      begin
        take(3'h0);
        chk("ded_take", 0, irq);
      end
    end
    bus(1'b1, `EPI_IDX_SENSE, 8'h00);
    wt;
    chk("level_req", 5'h01, vector_req);
    chk("level_wake", 1, wake);
    bus(1'b0, `EPI_IDX_FLAGS, 8'h00);
    chk("level_flag", 0, q);
    bus(1'b1, `EPI_IDX_GLOBAL, 8'h00);
    wt;
    chk("global_off", 0, irq);
    ded_req <= 1'b1;
    $display("test ded done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Clock
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_groups;
    t_ded;
    end_sim;
  end
  // Watchdog
  initial
  begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
endmodule
